// file: cpu_addr_pkg.sv
package cpu_addr_pkg;

    // axi4-lite geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // byte offsets of the register file
    localparam logic [11:0] OFF_ACCUMULATOR = 12'h000;
    localparam logic [11:0] OFF_INDEX_REGISTER = 12'h004;
    localparam logic [11:0] OFF_STACK_POINTER = 12'h008;
    localparam logic [11:0] OFF_PROGRAM_COUNTER_HIGH = 12'h00c;
    localparam logic [11:0] OFF_PROGRAM_COUNTER_LOW = 12'h010;
    localparam logic [11:0] OFF_FLAGS = 12'h014;
    localparam logic [11:0] OFF_COMMAND = 12'h018;
    localparam logic [11:0] OFF_STATUS = 12'h01c;
    // one data byte per word: ram window and register-space window
    localparam logic [1:0] WIN_RAM = 2'h1;
    localparam logic [1:0] WIN_REGSPACE = 2'h2;

    // values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h02;

    // flags register layout
    localparam int FLAG_GIE = 0;
    localparam int FLAG_ZERO = 1;
    localparam int FLAG_CARRY = 2;
    localparam int FLAG_SUPER = 3;
    localparam int FLAG_XIO = 4;
    localparam logic [7:0] FLAGS_WMASK = 8'h17;

    // command word layout
    localparam int CMD_MODE_LSB = 0;
    localparam int CMD_OP_LSB = 3;
    localparam int CMD_TGT_LSB = 6;
    localparam int CMD_SPACE_BIT = 8;
    localparam int CMD_OP1_LSB = 16;
    localparam int CMD_OP2_LSB = 24;

    // status layout
    localparam int STS_BUSY = 0;
    localparam int STS_ILLEGAL = 1;
    localparam int STS_LEN_LSB = 4;

    // instruction lengths in bytes
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        MODE_SRC_IMM = 3'h0,
        MODE_SRC_DIR = 3'h1,
        MODE_SRC_IDX = 3'h2,
        MODE_DST_DIR = 3'h3,
        MODE_DST_IDX = 3'h4,
        MODE_DST_DIR_SRC_IMM = 3'h5
    } addr_mode_t;

    typedef enum logic [2:0] {
        OP_MOV = 3'h0,
        OP_ADD = 3'h1,
        OP_AND = 3'h2,
        OP_OR = 3'h3,
        OP_XOR = 3'h4
    } alu_op_t;

    typedef enum logic [1:0] {
        TGT_ACC = 2'h0,
        TGT_IDX = 2'h1,
        TGT_SP = 2'h2,
        TGT_FLAGS = 2'h3
    } target_t;

    typedef enum logic [1:0] {
        REGION_NONE,
        REGION_CSR,
        REGION_RAM,
        REGION_REGSPACE
    } region_t;

    // gray coded except done -> idle (two bits flip): idle -> exec -> done -> idle
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DONE = 2'b11
    } exec_state_t;

endpackage

// file: cpu_alu.sv
`timescale 1ns/100ps
module cpu_alu
    import cpu_addr_pkg::*;
(
    input wire logic [2:0] op,
    input wire logic [7:0] dst_val,
    input wire logic [7:0] src_val,
    output logic [7:0] result,
    output logic carry,
    output logic legal
);

    logic [8:0] sum; // nine bits keep the carry out

    // combine the second source with the source byte
    always_comb begin
        sum = {1'b0, dst_val} + {1'b0, src_val};
        result = src_val;
        carry = 1'b0;
        legal = 1'b1;
        case (op)
            OP_MOV: begin
                result = src_val;
            end
            OP_ADD: begin
                result = sum[7:0];
                carry = sum[8];
            end
            OP_AND: begin
                result = dst_val & src_val;
            end
            OP_OR: begin
                result = dst_val | src_val;
            end
            OP_XOR: begin
                result = dst_val ^ src_val;
            end
            default: begin
                // unknown operation: nothing will be written
                legal = 1'b0;
            end
        endcase
    end

endmodule

// file: cpu_operand_addressing.sv
`timescale 1ns/100ps
module cpu_operand_addressing
    import cpu_addr_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [cpu_addr_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [cpu_addr_pkg::DATA_W-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [cpu_addr_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [cpu_addr_pkg::DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    import cpu_addr_pkg::*;

    // map a byte address onto a region of the register file
    function automatic region_t decode(input logic [11:0] addr);
        if (addr[1:0] != 2'h0) begin
            decode = REGION_NONE;
        end else if (addr[11:10] == WIN_RAM) begin
            decode = REGION_RAM;
        end else if (addr[11:10] == WIN_REGSPACE) begin
            decode = REGION_REGSPACE;
        end else if (addr <= OFF_STATUS) begin
            decode = REGION_CSR;
        end else begin
            decode = REGION_NONE;
        end
    endfunction

    // byte-lane merge for a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                merge[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
    endfunction

    // indexed address, carry out of bit 7 dropped on purpose
    function automatic logic [7:0] index_addr(input logic [7:0] base, input logic [7:0] ix);
        logic [8:0] s;
        s = {1'b0, base} + {1'b0, ix};
        index_addr = s[7:0];
    endfunction

    // architectural registers
    logic [7:0] acc_reg, acc_next; // accumulator
    logic [7:0] idx_reg, idx_next; // index register
    logic [7:0] sp_reg, sp_next; // stack pointer
    logic [7:0] pch_reg, pch_next; // program counter high byte
    logic [7:0] pcl_reg, pcl_next; // program counter low byte
    logic [7:0] flags_reg, flags_next; // flags
    logic [31:0] cmd_reg, cmd_next; // instruction being executed
    logic illegal_reg, illegal_next; // last instruction had a bad encoding
    logic [1:0] len_reg, len_next; // length of last instruction
    exec_state_t state_reg, state_next;

    // data memories, no reset: contents are undefined until written
    logic [7:0] ram [256];
    logic [7:0] regspace [256];
    logic mem_we; // write enable into one of the memories
    logic mem_we_space; // 1 selects register space
    logic [7:0] mem_waddr;
    logic [7:0] mem_wdata;

    // axi slave state
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic aw_held_reg, aw_held_next; // write address captured
    logic w_held_reg, w_held_next; // write data captured
    logic [11:0] waddr_reg, waddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;

    // decoded fields of the current instruction
    logic [2:0] f_mode;
    logic [2:0] f_op;
    logic [1:0] f_tgt;
    logic f_space;
    logic [7:0] f_op1;
    logic [7:0] f_op2;
    logic [7:0] mem_addr; // location read and, for destinations, written
    logic [7:0] mem_rd; // byte at mem_addr
    logic [7:0] alu_dst; // second arithmetic source
    logic [7:0] alu_src; // instruction source
    logic [7:0] alu_res;
    logic alu_carry;
    logic alu_legal;
    logic write_fire; // bus write performed this cycle
    region_t wregion;
    region_t rregion;
    logic [15:0] pc_sum;

    assign f_mode = cmd_reg[CMD_MODE_LSB +: 3];
    assign f_op = cmd_reg[CMD_OP_LSB +: 3];
    assign f_tgt = cmd_reg[CMD_TGT_LSB +: 2];
    assign f_space = cmd_reg[CMD_SPACE_BIT];
    assign f_op1 = cmd_reg[CMD_OP1_LSB +: 8];
    assign f_op2 = cmd_reg[CMD_OP2_LSB +: 8];
    assign mem_rd = f_space ? regspace[mem_addr] : ram[mem_addr];
    assign wregion = decode(waddr_reg);
    assign rregion = decode(S_AXI_ARADDR);

    cpu_alu u_alu (
        .op(f_op),
        .dst_val(alu_dst),
        .src_val(alu_src),
        .result(alu_res),
        .carry(alu_carry),
        .legal(alu_legal)
    );

    // operand routing per addressing mode
    always_comb begin
        mem_addr = f_op1;
        alu_dst = acc_reg;
        alu_src = f_op1;
        case (f_mode)
            MODE_SRC_IMM: begin
                alu_src = f_op1;
                case (f_tgt)
                    TGT_ACC: alu_dst = acc_reg;
                    TGT_IDX: alu_dst = idx_reg;
                    TGT_SP: alu_dst = sp_reg;
                    default: alu_dst = flags_reg;
                endcase
            end
            MODE_SRC_DIR, MODE_SRC_IDX: begin
                if (f_mode == MODE_SRC_IDX) begin
                    mem_addr = index_addr(f_op1, idx_reg);
                end
                alu_src = mem_rd;
                alu_dst = (f_tgt == TGT_IDX) ? idx_reg : acc_reg;
            end
            MODE_DST_DIR: begin
                alu_src = (f_tgt == TGT_IDX) ? idx_reg : acc_reg;
                alu_dst = mem_rd;
            end
            MODE_DST_IDX: begin
                mem_addr = index_addr(f_op1, idx_reg);
                alu_src = acc_reg;
                alu_dst = mem_rd;
            end
            MODE_DST_DIR_SRC_IMM: begin
                alu_src = f_op2;
                alu_dst = mem_rd;
            end
            default: begin
                alu_src = f_op1;
            end
        endcase
    end

    // execution engine and architectural registers
    always_comb begin
        acc_next = acc_reg;
        idx_next = idx_reg;
        sp_next = sp_reg;
        pch_next = pch_reg;
        pcl_next = pcl_reg;
        flags_next = flags_reg;
        cmd_next = cmd_reg;
        illegal_next = illegal_reg;
        len_next = len_reg;
        state_next = state_reg;
        mem_we = 1'b0;
        mem_we_space = f_space;
        mem_waddr = mem_addr;
        mem_wdata = alu_res;
        pc_sum = {pch_reg, pcl_reg};
        case (state_reg)
            ST_IDLE: begin
                // bus writes only land while idle, so they never race the engine
                if (write_fire && wregion == REGION_CSR) begin
                    case (waddr_reg)
                        OFF_ACCUMULATOR: if (wstrb_reg[0]) acc_next = wdata_reg[7:0];
                        OFF_INDEX_REGISTER: if (wstrb_reg[0]) idx_next = wdata_reg[7:0];
                        OFF_STACK_POINTER: if (wstrb_reg[0]) sp_next = wdata_reg[7:0];
                        OFF_PROGRAM_COUNTER_HIGH: if (wstrb_reg[0]) pch_next = wdata_reg[7:0];
                        OFF_PROGRAM_COUNTER_LOW: if (wstrb_reg[0]) pcl_next = wdata_reg[7:0];
                        OFF_FLAGS: begin
                            // supervisory bit is not software writable
                            if (wstrb_reg[0]) begin
                                flags_next = (flags_reg & ~FLAGS_WMASK) | (wdata_reg[7:0] & FLAGS_WMASK);
                            end
                        end
                        OFF_COMMAND: begin
                            cmd_next = merge(cmd_reg, wdata_reg, wstrb_reg);
                            state_next = ST_EXEC;
                        end
                        default: begin
                            // status is read only
                        end
                    endcase
                end else if (write_fire && wregion != REGION_NONE) begin
                    mem_we = 1'b1;
                    mem_we_space = (wregion == REGION_REGSPACE);
                    mem_waddr = waddr_reg[9:2];
                    mem_wdata = wdata_reg[7:0];
                end
            end
            ST_EXEC: begin
                state_next = ST_DONE;
                len_next = (f_mode == MODE_DST_DIR_SRC_IMM) ? LEN_THREE : LEN_TWO;
                illegal_next = !alu_legal || f_mode > MODE_DST_DIR_SRC_IMM;
                if (alu_legal && f_mode <= MODE_DST_DIR_SRC_IMM) begin
                    if (f_mode <= MODE_SRC_IDX) begin
                        // source modes: result lands in a cpu register
                        if (f_mode != MODE_SRC_IMM && f_tgt > TGT_IDX) begin
                            illegal_next = 1'b1;
                        end else begin
                            case (f_tgt)
                                TGT_ACC: acc_next = alu_res;
                                TGT_IDX: idx_next = alu_res;
                                TGT_SP: sp_next = alu_res;
                                default: begin
                                    // flags as destination keep the supervisory bit
                                    flags_next = (alu_res & FLAGS_WMASK) | (flags_reg & ~FLAGS_WMASK);
                                end
                            endcase
                        end
                    end else begin
                        mem_we = 1'b1;
                    end
                    // a refused target writes nothing, the flags included
                    if (!illegal_next && !(f_mode == MODE_SRC_IMM && f_tgt == TGT_FLAGS) && (f_op != OP_MOV ||
                        (f_mode <= MODE_SRC_IDX && f_tgt == TGT_ACC))) begin
                        flags_next[FLAG_ZERO] = (alu_res == 8'h00);
                        if (f_op == OP_ADD) begin
                            flags_next[FLAG_CARRY] = alu_carry;
                        end
                    end
                end
                // advance past the instruction, low byte carrying into high
                pc_sum = {pch_reg, pcl_reg} + {14'h0000, len_next};
                pch_next = pc_sum[15:8];
                pcl_next = pc_sum[7:0];
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // register the engine state
    always_ff @(posedge CLK) begin
        if (RESET) begin
            acc_reg <= RST_BYTE;
            idx_reg <= RST_BYTE;
            sp_reg <= RST_BYTE;
            pch_reg <= RST_BYTE;
            pcl_reg <= RST_BYTE;
            flags_reg <= RST_FLAGS;
            cmd_reg <= 32'h0000_0000;
            illegal_reg <= 1'b0;
            len_reg <= 2'h0;
            state_reg <= ST_IDLE;
        end else begin
            acc_reg <= acc_next;
            idx_reg <= idx_next;
            sp_reg <= sp_next;
            pch_reg <= pch_next;
            pcl_reg <= pcl_next;
            flags_reg <= flags_next;
            cmd_reg <= cmd_next;
            illegal_reg <= illegal_next;
            len_reg <= len_next;
            state_reg <= state_next;
        end
    end

    // memory write port
    always_ff @(posedge CLK) begin
        if (mem_we && mem_we_space) begin
            regspace[mem_waddr] <= mem_wdata;
        end
        if (mem_we && !mem_we_space) begin
            ram[mem_waddr] <= mem_wdata;
        end
    end

    // axi4-lite handshakes: address and data captured in either order
    always_comb begin
        aw_held_next = aw_held_reg;
        w_held_next = w_held_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        write_fire = aw_held_reg && w_held_reg && !bvalid_reg && state_reg == ST_IDLE;
        if (S_AXI_AWVALID && awready_reg) begin
            aw_held_next = 1'b1;
            waddr_next = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && wready_reg) begin
            w_held_next = 1'b1;
            wdata_next = S_AXI_WDATA;
            wstrb_next = S_AXI_WSTRB;
        end
        if (write_fire) begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = (wregion == REGION_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        if (bvalid_reg && S_AXI_BREADY) begin
            bvalid_next = 1'b0;
        end
        // ready stays low while a captured half waits or a response is pending
        awready_next = !aw_held_next && !bvalid_next;
        wready_next = !w_held_next && !bvalid_next;
        if (S_AXI_ARVALID && arready_reg) begin
            arready_next = 1'b0;
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = 32'h0000_0000;
            case (rregion)
                REGION_RAM: rdata_next[7:0] = ram[S_AXI_ARADDR[9:2]];
                REGION_REGSPACE: rdata_next[7:0] = regspace[S_AXI_ARADDR[9:2]];
                REGION_CSR: begin
                    case (S_AXI_ARADDR)
                        OFF_ACCUMULATOR: rdata_next[7:0] = acc_reg;
                        OFF_INDEX_REGISTER: rdata_next[7:0] = idx_reg;
                        OFF_STACK_POINTER: rdata_next[7:0] = sp_reg;
                        OFF_PROGRAM_COUNTER_HIGH: rdata_next[7:0] = pch_reg;
                        OFF_PROGRAM_COUNTER_LOW: rdata_next[7:0] = pcl_reg;
                        OFF_FLAGS: rdata_next[7:0] = flags_reg;
                        OFF_COMMAND: rdata_next = cmd_reg;
                        default: begin
                            rdata_next[STS_BUSY] = (state_reg != ST_IDLE);
                            rdata_next[STS_ILLEGAL] = illegal_reg;
                            rdata_next[STS_LEN_LSB +: 2] = len_reg;
                        end
                    endcase
                end
                default: rresp_next = RESP_SLVERR;
            endcase
        end
        if (rvalid_reg && S_AXI_RREADY) begin
            rvalid_next = 1'b0;
            arready_next = 1'b1;
        end
    end

    // register the bus state
    always_ff @(posedge CLK) begin
        if (RESET) begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            waddr_reg <= 12'h000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else begin
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            // arready rises the first cycle after reset
            arready_reg <= arready_next | (!arready_reg && !rvalid_reg);
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    assign S_AXI_AWREADY = awready_reg;
    assign S_AXI_WREADY = wready_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = arready_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RRESP = rresp_reg;
    assign S_AXI_RDATA = rdata_reg;

endmodule

// file: cpu_operand_addressing_asserts.sv
`timescale 1ns/100ps
module cpu_operand_addressing_chk
    import cpu_addr_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [11:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    // one domain, so clock and reset are given once
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    AST_B_STANDS: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped early");
    AST_R_STANDS: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped early");
    AST_R_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    AST_AR_BLOCK: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("address taken with read pending");
    AST_W_BLOCK: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write taken with response pending");
    // bvalid may wait two extra cycles while a command executes
    AST_B_BOUND: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |-> ##[1:4] S_AXI_BVALID)
        else $error("write response missing");
    AST_AR_BACK: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID ##1 S_AXI_ARREADY)
        else $error("read channel not reopened");
    AST_B_DONE: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
        else $error("write response repeated");
    // the supervisory bit and the reserved bits can never be set from software
    AST_FLAGS_SUPER: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == OFF_FLAGS
        |=> S_AXI_RDATA[7:5] == 3'h0 && !S_AXI_RDATA[FLAG_SUPER])
        else $error("flags read shows a bit software cannot set");
    cover property (S_AXI_BVALID && S_AXI_BREADY && S_AXI_BRESP == RESP_OKAY);
    cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);
    cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_OKAY);
endmodule
bind cpu_operand_addressing cpu_operand_addressing_chk chk (.*);

// file: cpu_operand_addressing_tb_top.sv
`timescale 1ns/100ps
`define CK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module cpu_operand_addressing_tb_top;
    import cpu_addr_pkg::*;
    logic clk = 0;
    logic rst = 1;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, r_d, d;
    logic aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0, aw_rdy, w_rdy, b_v, ar_rdy, r_v;
    logic [1:0] b_rsp, r_rsp, rs;
    logic [15:0] pc = 0; // expected program counter
    logic [8:0] s;
    logic [7:0] a, x, v, m;
    int err_count = 0, n_checks = 0;
    always #25 clk = ~clk;
    cpu_operand_addressing uut (.CLK(clk), .RESET(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(aw_v),
        .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_rdy),
        .S_AXI_BRESP(b_rsp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(ar_v),
        .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(r_d), .S_AXI_RRESP(r_rsp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r));
    task results;
        $display("errors %0d checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // address and data go out together; each drops at its own handshake
    task wr(input logic [11:0] ad, input logic [31:0] dt);
        @(posedge clk);
        awa <= ad;
        wd <= dt;
        aw_v <= 1;
        w_v <= 1;
        b_r <= 1;
        do begin
            @(posedge clk);
            if (aw_rdy) aw_v <= 0;
            if (w_rdy) w_v <= 0;
        end while (b_v !== 1'b1);
        b_r <= 0;
    endtask
    task rd(input logic [11:0] ad, output logic [31:0] dt, output logic [1:0] rp);
        @(posedge clk);
        ara <= ad;
        ar_v <= 1;
        r_r <= 1;
        do begin
            @(posedge clk);
            if (ar_rdy) ar_v <= 0;
        end while (r_v !== 1'b1);
        dt = r_d;
        rp = r_rsp;
        r_r <= 0;
    endtask
    task chk(input logic [11:0] ad, input logic [7:0] e);
        rd(ad, d, rs);
        `CK(d, {24'h0, e})
    endtask
    // busy lasts two cycles, so four idle cycles cover execution
    task exe(input logic [2:0] md, op, input logic [1:0] tg, input logic sp, input logic [7:0] o1, o2);
        wr(OFF_COMMAND, {o2, o1, 7'h0, sp, tg, op, md});
        pc += (md == MODE_DST_DIR_SRC_IMM) ? 3 : 2;
        repeat (4) @(posedge clk);
    endtask
    function automatic logic [7:0] alu(input logic [2:0] op, input logic [7:0] p, q);
        case (op)
            OP_ADD: return p + q;
            OP_AND: return p & q;
            OP_OR: return p | q;
            OP_XOR: return p ^ q;
            default: return q;
        endcase
    endfunction
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        results;
    end
    initial begin
        a = $urandom(32'h428d);
        repeat (12) @(posedge clk);
        rst <= 0;
        for (int i = 0; i < 5; i++) chk(12'(i * 4), 8'h00);
        chk(OFF_FLAGS, 8'h02);
        rd(12'h020, d, rs);
        `CK(rs, RESP_SLVERR)
        v = $urandom;
        m = $urandom;
        exe(MODE_SRC_IMM, OP_MOV, TGT_ACC, 0, a, 0);
        exe(MODE_SRC_IMM, OP_MOV, TGT_IDX, 0, 8'h30, 0);
        exe(MODE_SRC_IMM, OP_ADD, TGT_ACC, 0, v, 0);
        s = a + v;
        chk(OFF_ACCUMULATOR, s[7:0]);
        chk(OFF_FLAGS, {5'h0, s[8], s[7:0] == 8'h0, 1'b0});
        exe(MODE_SRC_IMM, OP_AND, TGT_FLAGS, 0, m, 0);
        chk(OFF_FLAGS, {5'h0, s[8], s[7:0] == 8'h0, 1'b0} & m & 8'h17);
        a = s[7:0];
        // the indexed sum must wrap to land on 0x10
        wr({WIN_RAM, 8'h10, 2'b00}, {24'h0, v});
        exe(MODE_SRC_IDX, OP_ADD, TGT_ACC, 0, 8'he0, 0);
        a = a + v;
        chk(OFF_ACCUMULATOR, a);
        exe(MODE_SRC_DIR, OP_XOR, TGT_IDX, 0, 8'h10, 0);
        x = 8'h30 ^ v;
        chk(OFF_INDEX_REGISTER, x);
        for (int i = 0; i < 5; i++) begin
            m = $urandom;
            exe(MODE_SRC_IMM, 3'(i), TGT_IDX, 0, m, 0);
            x = alu(3'(i), x, m);
            chk(OFF_INDEX_REGISTER, x);
        end
        exe(MODE_DST_DIR, OP_ADD, TGT_ACC, 0, 8'h10, 0);
        chk({WIN_RAM, 8'h10, 2'b00}, v + a);
        chk(OFF_ACCUMULATOR, a);
        exe(MODE_DST_DIR, OP_MOV, TGT_ACC, 1, 8'h05, 0);
        chk({WIN_REGSPACE, 8'h05, 2'b00}, a);
        chk(OFF_ACCUMULATOR, a);
        wr({WIN_RAM, 8'h20, 2'b00}, {24'h0, m});
        exe(MODE_DST_IDX, OP_OR, TGT_ACC, 0, 8'h20 - x, 0);
        chk({WIN_RAM, 8'h20, 2'b00}, m | a);
        wr({WIN_RAM, 8'h31, 2'b00}, {24'h0, m});
        exe(MODE_DST_DIR_SRC_IMM, OP_ADD, TGT_ACC, 0, 8'h31, v);
        chk({WIN_RAM, 8'h31, 2'b00}, m + v);
        chk(OFF_STATUS, {2'h0, LEN_THREE, 4'h0});
        exe(MODE_SRC_IMM, OP_MOV, TGT_SP, 0, v, 0);
        chk(OFF_STACK_POINTER, v);
        // refused encodings write nothing, yet the length still counts
        rd(OFF_FLAGS, d, rs);
        exe(MODE_SRC_DIR, OP_ADD, TGT_SP, 0, 8'h10, 0);
        chk(OFF_FLAGS, d[7:0]);
        chk(OFF_STACK_POINTER, v);
        exe(MODE_SRC_IMM, 3'h7, TGT_ACC, 0, v, 0);
        chk(OFF_ACCUMULATOR, a);
        chk(OFF_STATUS, {2'h0, LEN_TWO, 4'h2});
        chk(OFF_PROGRAM_COUNTER_HIGH, pc[15:8]);
        chk(OFF_PROGRAM_COUNTER_LOW, pc[7:0]);
        results;
    end
endmodule
